/* File: design/gpio_params.svh */
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ======================================================================
// register indexes (byte address is four times the index)
`define FIRST_LATCH_IDX 30'h0000_0001
`define SECOND_LATCH_IDX 30'h0000_0002
`define FIRST_DIR_IDX 30'h0000_0005
`define SECOND_DIR_IDX 30'h0000_0006

// ======================================================================
// field positions and reset values
`define CLK_OUT_EN_BIT 7
`define CLK_OUT_PIN 2
`define DIR_RESET 8'h00
`define CLK_OUT_EN_RESET 1'b0

// ======================================================================
// channel select codes and bus encodings
`define CHAN_SEL_W 5
`define FIRST_CHAN_BASE 5'h00
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

/* File: design/gpio_pkg.sv */
package gpio_pkg;

   // ===================================================================
   // shared types
   typedef logic [31:0] word_t;
   typedef logic [4:0] chan_sel_t;

   // which register an address phase selected
   typedef enum logic [2:0] {
      reg_none,
      reg_first_latch,
      reg_second_latch,
      reg_first_dir,
      reg_second_dir
   } reg_sel_t;

endpackage

/* File: design/gpio_ports.sv */
`timescale 1ns/10ps
`include "gpio_params.svh"

// Behaviour
// - the first port keeps an eight-bit data latch that no reset alters.
// - a first-port direction bit of 1 drives the latch out, 0 leaves input.
// - reset clears all first-port direction bits, so every pin is input.
// - a first-port read gives the latch bit wherever direction is 1.
// - with direction 0 a read gives the pin, or 0 if the converter has it.
// - data writes always load the latches and never change what inputs read.
// - a pin the converter uses stays a high-impedance input whatever its dir.
// - the five-bit channel select decides which first-port pin is analog.
// - the second port keeps a five-bit data latch that no reset alters.
// - a second-port direction bit of 1 drives the pin, 0 leaves it input.
// - reset clears second-port direction and the bus clock output enable.
// - enable bit 7 of second-port direction drives the bus clock on pin 2.
// - with the clock out on, pin 2 drives mclk whatever its dir; reads give the latch.
// - a second-port read gives latch where direction is 1, else the pin.

module gpio_ports #(
   parameter int FIRST_W = 8,
   parameter int SECOND_W = 5
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic hsel,
   input wire gpio_pkg::word_t haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire gpio_pkg::word_t hwdata,
   input wire logic hready,
   output gpio_pkg::word_t hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [FIRST_W-1:0] first_pin_in,
   output logic [FIRST_W-1:0] first_pin_out,
   output logic [FIRST_W-1:0] first_pin_oe,
   input wire logic [SECOND_W-1:0] second_pin_in,
   output logic [SECOND_W-1:0] second_pin_out,
   output logic [SECOND_W-1:0] second_pin_oe,
   input wire gpio_pkg::chan_sel_t converter_channel_select
);
   import gpio_pkg::*;

   // ===================================================================
   // elaboration checks
   // refused when the design is built, before any clock runs
   if (FIRST_W < 1 || FIRST_W > 8) begin
      $error("first port width must be 1 to 8");
   end
   if (SECOND_W <= `CLK_OUT_PIN || SECOND_W > 7) begin
      $error("second port width must be 3 to 7");
   end

   // ===================================================================
   // helpers
   // one-hot mask of the first-port pin the converter has claimed
   function automatic logic [FIRST_W-1:0] chan_mask(input chan_sel_t sel);
      logic [FIRST_W-1:0] m;
      m = '0;
      for (int i = 0; i < FIRST_W; i++) begin
         if (sel == chan_sel_t'(`FIRST_CHAN_BASE + i))
            m[i] = 1'b1;
      end
      return m;
   endfunction

   // word-aligned address decode
   function automatic reg_sel_t decode(input word_t a);
      if (a[1:0] != 2'b00) begin
         return reg_none;
      end else if (a[31:2] == `FIRST_LATCH_IDX) begin
         return reg_first_latch;
      end else if (a[31:2] == `SECOND_LATCH_IDX) begin
         return reg_second_latch;
      end else if (a[31:2] == `FIRST_DIR_IDX) begin
         return reg_first_dir;
      end else if (a[31:2] == `SECOND_DIR_IDX) begin
         return reg_second_dir;
      end else begin
         return reg_none;
      end
   endfunction

   // ===================================================================
   // state
   logic [FIRST_W-1:0] first_latch_r, first_latch_nxt;
   logic [FIRST_W-1:0] first_dir_r, first_dir_nxt;
   logic [SECOND_W-1:0] second_latch_r, second_latch_nxt;
   logic [SECOND_W-1:0] second_dir_r, second_dir_nxt;
   logic clk_out_en_r, clk_out_en_nxt;
   logic ap_valid_r, ap_valid_nxt;
   logic ap_write_r, ap_write_nxt;
   reg_sel_t ap_reg_r, ap_reg_nxt;
   word_t hrdata_r, hrdata_nxt;
   logic hreadyout_r;
   logic hresp_r;
   logic [FIRST_W-1:0] first_oe_r, first_oe_nxt;
   logic [SECOND_W-1:0] second_oe_r, second_oe_nxt;
   logic [FIRST_W-1:0] claimed;
   logic take;
   logic first_cycle_r;

   assign claimed = chan_mask(converter_channel_select);
   assign take = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

   // ===================================================================
   // register writes, done in the data phase with hwdata
   always_comb begin
      first_latch_nxt = first_latch_r;
      second_latch_nxt = second_latch_r;
      first_dir_nxt = first_dir_r;
      second_dir_nxt = second_dir_r;
      clk_out_en_nxt = clk_out_en_r;
      if (ap_valid_r && ap_write_r) begin
         case (ap_reg_r)
            // latches load regardless of direction
            reg_first_latch: first_latch_nxt = hwdata[FIRST_W-1:0];
            reg_second_latch: begin
               // upper bits have no storage, so are dropped
               second_latch_nxt = hwdata[SECOND_W-1:0];
            end
            reg_first_dir: first_dir_nxt = hwdata[FIRST_W-1:0];
            reg_second_dir: begin
               second_dir_nxt = hwdata[SECOND_W-1:0];
               clk_out_en_nxt = hwdata[`CLK_OUT_EN_BIT];
            end
            default: ;
         endcase
      end
   end

   // data latches have no reset on purpose; they hold across any reset
   always_ff @(posedge mclk) begin
      first_latch_r <= first_latch_nxt;
      second_latch_r <= second_latch_nxt;
   end

   // direction and clock enable clear on reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         first_dir_r <= FIRST_W'(`DIR_RESET);
         second_dir_r <= SECOND_W'(`DIR_RESET);
         clk_out_en_r <= `CLK_OUT_EN_RESET;
      end else begin
         first_dir_r <= first_dir_nxt;
         second_dir_r <= second_dir_nxt;
         clk_out_en_r <= clk_out_en_nxt;
      end
   end

   // ===================================================================
   // bus address phase capture and read data
   // read data is built from the next register values, so a read right
   // behind a write to the same register sees the new value
   always_comb begin
      ap_valid_nxt = 1'b0;
      ap_write_nxt = 1'b0;
      ap_reg_nxt = reg_none;
      hrdata_nxt = hrdata_r;
      if (take) begin
         ap_valid_nxt = 1'b1;
         ap_write_nxt = hwrite;
         ap_reg_nxt = decode(haddr);
         if (!hwrite) begin
            hrdata_nxt = '0;
            case (decode(haddr))
               reg_first_latch: begin
                  // latch where driven; pin or 0 where input
                  hrdata_nxt[FIRST_W-1:0] =
                     (first_dir_nxt & first_latch_nxt) |
                     (~first_dir_nxt & ~claimed & first_pin_in);
               end
               reg_second_latch: begin
                  hrdata_nxt[SECOND_W-1:0] =
                     (second_dir_nxt & second_latch_nxt) |
                     (~second_dir_nxt & second_pin_in);
                  if (clk_out_en_nxt)
                     hrdata_nxt[`CLK_OUT_PIN] =
                        second_latch_nxt[`CLK_OUT_PIN];
               end
               reg_first_dir: hrdata_nxt[FIRST_W-1:0] = first_dir_nxt;
               reg_second_dir: begin
                  hrdata_nxt[SECOND_W-1:0] = second_dir_nxt;
                  hrdata_nxt[`CLK_OUT_EN_BIT] = clk_out_en_nxt;
               end
               default: hrdata_nxt = '0;
            endcase
         end
      end
   end

   // zero wait states, so hreadyout is high in reset and never drops
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_reg_r <= reg_none;
         hrdata_r <= '0;
         hreadyout_r <= 1'b1;
         hresp_r <= `HRESP_OKAY;
         first_cycle_r <= 1'b1;
      end else begin
         ap_valid_r <= ap_valid_nxt;
         ap_write_r <= ap_write_nxt;
         ap_reg_r <= ap_reg_nxt;
         hrdata_r <= hrdata_nxt;
         hreadyout_r <= 1'b1;
         hresp_r <= `HRESP_OKAY;
         first_cycle_r <= 1'b0;
      end
   end

   // ===================================================================
   // pin drivers
   // a claimed pin is never driven, whatever its direction bit
   always_comb begin
      first_oe_nxt = first_dir_nxt & ~claimed;
      second_oe_nxt = second_dir_nxt;
      if (clk_out_en_nxt)
         second_oe_nxt[`CLK_OUT_PIN] = 1'b1;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         first_oe_r <= '0;
         second_oe_r <= '0;
      end else begin
         first_oe_r <= first_oe_nxt;
         second_oe_r <= second_oe_nxt;
      end
   end

   // ===================================================================
   // outputs
   // the clock pin passes mclk itself; a flop could not run at that rate
   always_comb begin
      second_pin_out = second_latch_r;
      if (clk_out_en_r)
         second_pin_out[`CLK_OUT_PIN] = mclk;
   end

   assign first_pin_out = first_latch_r;
   assign first_pin_oe = first_oe_r;
   assign second_pin_oe = second_oe_r;
   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;

   // ===================================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   logic rd_first, rd_second;
   assign rd_first = ap_valid_r && !ap_write_r &&
                     ap_reg_r == reg_first_latch;
   assign rd_second = ap_valid_r && !ap_write_r &&
                      ap_reg_r == reg_second_latch;

   a_dir_after_reset: assert property (
      first_cycle_r |-> first_dir_r == '0 && second_dir_r == '0 &&
         !clk_out_en_r && first_pin_oe == '0 && second_pin_oe == '0)
      else $error("direction not clear after reset");

   a_first_read_latch: assert property (
      rd_first |-> ((hrdata[FIRST_W-1:0] ^ first_latch_r) & first_dir_r)
         == '0)
      else $error("first port read missed latch bit");

   a_first_read_pin: assert property (
      rd_first |-> (hrdata[FIRST_W-1:0] & ~first_dir_r) ==
         ($past(first_pin_in) & ~first_dir_r &
          ~chan_mask($past(converter_channel_select))))
      else $error("first port input read wrong");

   a_claimed_not_driven: assert property (
      (first_pin_oe & chan_mask($past(converter_channel_select))) == '0)
      else $error("claimed pin driven");

   a_first_oe_dir: assert property (
      first_pin_oe ==
         (first_dir_r & ~chan_mask($past(converter_channel_select))))
      else $error("first port enable disagrees with direction");

   a_latch_write: assert property (
      ap_valid_r && ap_write_r && ap_reg_r == reg_second_latch |=>
         second_latch_r == $past(hwdata[SECOND_W-1:0]))
      else $error("second latch write lost");

   a_second_read: assert property (
      rd_second && !clk_out_en_r |-> hrdata[SECOND_W-1:0] ==
         ((second_dir_r & second_latch_r) |
          (~second_dir_r & $past(second_pin_in))))
      else $error("second port read wrong");

   a_clk_pin_oe: assert property (
      clk_out_en_r |-> second_pin_oe[`CLK_OUT_PIN] &&
         (!rd_second || hrdata[`CLK_OUT_PIN] ==
          second_latch_r[`CLK_OUT_PIN]))
      else $error("clock pin not under enable");

   a_upper_zero: assert property (
      rd_second |-> hrdata[31:SECOND_W] == '0)
      else $error("second port upper bits not zero");

   c_claimed_read: cover property (
      rd_first && (~first_dir_r &
         chan_mask($past(converter_channel_select))) != '0);
   c_clock_out: cover property ($rose(clk_out_en_r));
   c_write_then_read: cover property (
      ap_valid_r && ap_write_r ##[1:3] rd_first);

endmodule

/* File: verification/pin_model.sv */
`timescale 1ns/10ps

// far side of one port: pads with an outside driver behind them
module pin_model #(
   parameter int W = 8
) (
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] ext,
   output logic [W-1:0] pin_in
);
   // ==========
   // pad level: driven pads show the buffer, released pads the outside
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

/* File: verification/gpio_ports_b_c_adc_clkout_tb.sv */
`timescale 1ns/10ps
`include "gpio_params.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, s); end end

module gpio_ports_b_c_adc_clkout_tb;
   import gpio_pkg::*;
   logic mclk, resetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   word_t haddr, hwdata, hrdata, r;
   logic [7:0] f_in, f_out, f_oe, f_ext;
   logic [4:0] s_in, s_out, s_oe, s_ext;
   chan_sel_t chan;
   int fails = 0, num_checks = 0, cyc = 0;
   localparam word_t FL = {`FIRST_LATCH_IDX, 2'b00};
   localparam word_t SL = {`SECOND_LATCH_IDX, 2'b00};
   localparam word_t FD = {`FIRST_DIR_IDX, 2'b00};
   localparam word_t SD = {`SECOND_DIR_IDX, 2'b00};
   assign hready = hreadyout;

   gpio_ports dut (.mclk(mclk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .first_pin_in(f_in),
      .first_pin_out(f_out), .first_pin_oe(f_oe), .second_pin_in(s_in),
      .second_pin_out(s_out), .second_pin_oe(s_oe),
      .converter_channel_select(chan));
   pin_model #(.W(8)) pf (.pin_out(f_out), .pin_oe(f_oe), .ext(f_ext),
      .pin_in(f_in));
   pin_model #(.W(5)) ps (.pin_out(s_out), .pin_oe(s_oe), .ext(s_ext),
      .pin_in(s_in));

   // ==========
   // clock and a cycle ceiling so a stuck handshake cannot hang the run
   initial begin
      mclk = 0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         conclude();
      end
   end

   // ==========
   // one single-word transfer: address phase, then data phase
   task automatic xfer(input word_t a, input logic w, input word_t d);
      @(posedge mclk);
      hsel <= 1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic t_reset;
      xfer(FD, 0, 0); `CHK("fdir", 32'h0, r)
      xfer(SD, 0, 0); `CHK("sdir", 32'h0, r)
      `CHK("oe", 13'h0, {f_oe, s_oe})
      `CHK("hresp", 1'b0, hresp)
      $display("test reset done");
   endtask

   task automatic t_first;
      f_ext <= 8'h3c;
      chan <= 5'h1f;
      xfer(FL, 1, 32'ha5);
      xfer(FD, 1, 32'h0f);
      settle();
      `CHK("f_oe", 8'h0f, f_oe)
      `CHK("f_out", 8'ha5, f_out)
      xfer(FL, 0, 0); `CHK("fread", 32'h35, r)
      xfer(FD, 0, 0); `CHK("fdir", 32'h0f, r)
      chan <= 5'h02;
      settle();
      `CHK("claim oe", 8'h0b, f_oe)
      xfer(FL, 0, 0); `CHK("claim rd", 32'h35, r)
      chan <= 5'h05;
      xfer(FL, 0, 0); `CHK("claim in", 32'h15, r)
      chan <= 5'h1f;
      $display("test first port done");
   endtask

   task automatic t_second;
      s_ext <= 5'h0a;
      xfer(SL, 1, 32'hff);
      xfer(SD, 1, 32'h03);
      settle();
      `CHK("s_oe", 5'h03, s_oe)
      xfer(SL, 0, 0); `CHK("sread", 32'h0b, r)
      xfer(SD, 1, 32'h83);
      settle();
      `CHK("clk oe", 5'h07, s_oe)
      #24 `CHK("clk hi", 1'b1, s_out[2])
      #50 `CHK("clk lo", 1'b0, s_out[2])
      xfer(SD, 0, 0); `CHK("sdir", 32'h83, r)
      xfer(SL, 0, 0); `CHK("clk rd", 32'h0f, r)
      xfer(32'h40, 0, 0); `CHK("unmapped", 32'h0, r)
      $display("test second port done");
   endtask

   // a mid-run reset must clear directions but keep both latches
   task automatic t_keep;
      @(posedge mclk);
      resetn <= 0;
      repeat (2) @(posedge mclk);
      resetn <= 1;
      `CHK("rst oe", 13'h0, {f_oe, s_oe})
      xfer(FD, 1, 32'hff);
      xfer(FL, 0, 0); `CHK("keep f", 32'ha5, r)
      xfer(SD, 1, 32'h1f);
      xfer(SL, 0, 0); `CHK("keep s", 32'h1f, r)
      $display("test reset keep done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      resetn = 0;
      hsel = 0;
      haddr = 0;
      htrans = 0;
      hwrite = 0;
      hwdata = 0;
      f_ext = 8'h00;
      s_ext = 5'h00;
      chan = 5'h1f;
      repeat (10) @(posedge mclk);
      resetn <= 1;
      t_reset();
      t_first();
      t_second();
      t_keep();
      conclude();
   end
endmodule
